// ---- src/i2css_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
module i2css_slave (
    input wire logic clock,
    input wire logic rst_n,
    i2css_if.slave bus,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] ctrl_r;
    logic [7:0] addr_r;
    logic [7:0] tx_buf_r;
    logic [7:0] rx_data_r;
    logic [7:0] st_r;
    logic [7:0] st_set_r;
    logic [7:0] st_hclr_r;
    logic [7:0] rdata_r;
    logic [3:0] hold_r;
    logic dual_r;
    logic dir_r;
    wire wr_ctrl = sfr_wr && (sfr_addr == i2css_pkg::CTRL_OFS);
    wire wr_stat = sfr_wr && (sfr_addr == i2css_pkg::STAT_OFS);
    wire wr_addr = sfr_wr && (sfr_addr == i2css_pkg::ADDR_OFS);
    wire wr_data = sfr_wr && (sfr_addr == i2css_pkg::DATA_OFS);
    wire rd_data = sfr_rd && (sfr_addr == i2css_pkg::DATA_OFS);
    wire srst = ctrl_r[i2css_pkg::CTRL_SRST];
    wire stretch_enable = ctrl_r[i2css_pkg::CTRL_STRETCH];
    wire spike_filter_enable = ctrl_r[i2css_pkg::CTRL_FILT];
    wire [7:0] ctrl_rd = {3'h0, st_r[i2css_pkg::ST_START], 3'h0, dir_r};
    // software clears: zero written to stop/restart/match, rx by data read
    wire [7:0] sw_clr_stat = wr_stat ? (i2css_pkg::SW_CLR_MASK & ~sfr_wdata) : 8'h00;
    wire [7:0] sw_clr_rd = rd_data ? 8'h84 : 8'h00;
    wire [7:0] sw_clr_wr = wr_data ? 8'h09 : 8'h00;
    wire [7:0] st_clr = sw_clr_stat | sw_clr_rd | sw_clr_wr | st_hclr_r;
    wire [7:0] rd_mux = (sfr_addr == i2css_pkg::CTRL_OFS) ? ctrl_rd :
                        (sfr_addr == i2css_pkg::STAT_OFS) ? st_r :
                        (sfr_addr == i2css_pkg::ADDR_OFS) ? addr_r :
                        (sfr_addr == i2css_pkg::DATA_OFS) ? rx_data_r : 8'h00;
    assign sfr_rdata = rdata_r;
    assign irq = |(st_r & ctrl_r & i2css_pkg::IRQ_MASK);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= i2css_pkg::REG_RESET;
            addr_r <= i2css_pkg::REG_RESET;
            tx_buf_r <= i2css_pkg::REG_RESET;
            dual_r <= 1'b0;
            hold_r <= 4'h0;
            rdata_r <= i2css_pkg::REG_RESET;
            st_r <= i2css_pkg::REG_RESET;
        end else begin
            if (wr_ctrl) ctrl_r <= sfr_wdata;
            if (wr_addr) addr_r <= sfr_wdata;
            else if (srst) addr_r <= i2css_pkg::REG_RESET;
            if (wr_data) tx_buf_r <= sfr_wdata;
            if (wr_stat) begin
                dual_r <= sfr_wdata[i2css_pkg::STW_DUAL];
                hold_r <= sfr_wdata[3:0];
            end
            if (sfr_rd) rdata_r <= rd_mux;
            st_r <= st_set_r | (st_r & ~st_clr);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // line sampling, filter, events; bit1 scl, bit0 sda
    logic [1:0] sy1_r;
    logic [1:0] sy2_r;
    logic [1:0] hist_r;
    logic [1:0] ln_r;
    logic [1:0] pv_r;
    wire [1:0] ln_nxt = (!spike_filter_enable || (sy2_r == hist_r)) ? sy2_r : ln_r;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sy1_r <= 2'h3;
            sy2_r <= 2'h3;
            hist_r <= 2'h3;
            ln_r <= 2'h3;
            pv_r <= 2'h3;
        end else begin
            sy1_r <= {bus.scl, bus.sda};
            sy2_r <= sy1_r;
            hist_r <= sy2_r;
            ln_r <= ln_nxt;
            pv_r <= ln_r;
        end
    end
    wire scl_s = ln_r[1];
    wire sda_s = ln_r[0];
    wire scl_rise = scl_s && !pv_r[1];
    wire scl_fall = !scl_s && pv_r[1];
    wire start_ev = scl_s && pv_r[1] && pv_r[0] && !sda_s;
    wire stop_ev = scl_s && pv_r[1] && !pv_r[0] && sda_s;

    ////////////////////////////////////////////////////////////////////////
    // protocol engine
    i2css_pkg::i2css_sst_e state_r;
    logic [7:0] sh_r;
    logic [7:0] tx_save_r;
    logic [3:0] cnt_r;
    logic [4:0] dly_r;
    logic want_r;
    logic sda_oe_r;
    logic first_pend_r;
    logic rls_r;
    wire addr_hit = addr_r[i2css_pkg::ADR_EN] &&
                    ((addr_r[6:0] == sh_r[7:1]) || (dual_r && (addr_r[6:1] == sh_r[7:2])));
    wire byte_done = (cnt_r == i2css_pkg::BYTE_BITS);
    wire rx_busy = st_r[i2css_pkg::ST_RXB];
    wire tx_busy = st_r[i2css_pkg::ST_TXB];
    wire [7:0] tx_src = (st_r[i2css_pkg::ST_NACK] || tx_busy) ? tx_save_r : tx_buf_r;
    wire [4:0] dly_load = {1'b0, hold_r} + i2css_pkg::HOLD_BASE;
    assign bus.s_scl_o = 1'b0;
    assign bus.s_sda_o = 1'b0;
    // stretch holds scl low
    // scl stays held until the first sda level after a stretch has settled
    assign bus.s_scl_oe = (state_r == i2css_pkg::S_HOLD) || rls_r;
    assign bus.s_sda_oe = sda_oe_r;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= i2css_pkg::S_IDLE;
            sh_r <= 8'h00;
            tx_save_r <= 8'h00;
            cnt_r <= 4'h0;
            dly_r <= 5'h00;
            want_r <= 1'b0;
            sda_oe_r <= 1'b0;
            first_pend_r <= 1'b0;
            dir_r <= 1'b0;
            rls_r <= 1'b0;
            st_set_r <= 8'h00;
            st_hclr_r <= 8'h00;
            rx_data_r <= 8'h00;
        end else begin
            st_set_r <= 8'h00;
            st_hclr_r <= 8'h00;
            if (dly_r != 5'h00) dly_r <= dly_r - 5'h01;
            if (dly_r == i2css_pkg::DLY_FIRE) sda_oe_r <= want_r;
            if (dly_r == 5'h00) rls_r <= 1'b0;
            if (srst) begin
                state_r <= i2css_pkg::S_IDLE;
                sda_oe_r <= 1'b0;
                want_r <= 1'b0;
            end else if (stop_ev) begin
                st_set_r[i2css_pkg::ST_STOP] <= 1'b1;
                st_hclr_r[i2css_pkg::ST_START] <= 1'b1;
                state_r <= i2css_pkg::S_IDLE;
                sda_oe_r <= 1'b0;
                want_r <= 1'b0;
            end else if (start_ev) begin
                st_set_r[i2css_pkg::ST_START] <= 1'b1;
                st_set_r[i2css_pkg::ST_RESTART] <= st_r[i2css_pkg::ST_START];
                state_r <= i2css_pkg::S_ADDR;
                cnt_r <= 4'h0;
                sda_oe_r <= 1'b0;
                want_r <= 1'b0;
            end else begin
                case (state_r)
                    i2css_pkg::S_ADDR, i2css_pkg::S_RX: begin
                        if (scl_rise) begin
                            sh_r <= {sh_r[6:0], sda_s};
                            cnt_r <= cnt_r + 4'h1;
                        end else if (scl_fall && byte_done) begin
                            cnt_r <= 4'h0;
                            dly_r <= dly_load;
                            if (state_r == i2css_pkg::S_ADDR) begin
                                if (addr_hit) begin
                                    st_set_r[i2css_pkg::ST_ADDRM] <= 1'b1;
                                    dir_r <= sh_r[0];
                                    first_pend_r <= 1'b1;
                                    want_r <= 1'b1;
                                    state_r <= i2css_pkg::S_ACK;
                                end else begin
                                    state_r <= i2css_pkg::S_IDLE;
                                end
                            end else if (rx_busy) begin
                                want_r <= 1'b0;
                                state_r <= stretch_enable ? i2css_pkg::S_HOLD : i2css_pkg::S_IDLE;
                            end else begin
                                rx_data_r <= sh_r;
                                st_set_r[i2css_pkg::ST_RXB] <= 1'b1;
                                st_set_r[i2css_pkg::ST_FIRST] <= first_pend_r;
                                first_pend_r <= 1'b0;
                                want_r <= 1'b1;
                                state_r <= i2css_pkg::S_ACK;
                            end
                        end
                    end
                    i2css_pkg::S_ACK: begin
                        if (scl_fall) begin
                            dly_r <= dly_load;
                            if (dir_r) begin
                                sh_r <= tx_src;
                                tx_save_r <= tx_src;
                                st_set_r[i2css_pkg::ST_TXB] <= 1'b1;
                                want_r <= !tx_src[7];
                                state_r <= i2css_pkg::S_TX;
                            end else begin
                                want_r <= 1'b0;
                                state_r <= i2css_pkg::S_RX;
                            end
                        end
                    end
                    i2css_pkg::S_TX: begin
                        if (scl_rise) begin
                            cnt_r <= cnt_r + 4'h1;
                        end else if (scl_fall) begin
                            dly_r <= dly_load;
                            if (byte_done) begin
                                cnt_r <= 4'h0;
                                want_r <= 1'b0;
                                state_r <= i2css_pkg::S_MACK;
                            end else begin
                                sh_r <= {sh_r[6:0], 1'b0};
                                want_r <= !sh_r[6];
                            end
                        end
                    end
                    i2css_pkg::S_MACK: begin
                        if (scl_rise) begin
                            if (sda_s) begin
                                st_set_r[i2css_pkg::ST_NACK] <= 1'b1;
                                state_r <= i2css_pkg::S_IDLE;
                            end else begin
                                st_hclr_r[i2css_pkg::ST_NACK] <= 1'b1;
                                cnt_r <= i2css_pkg::ACK_SEEN;
                            end
                        end else if (scl_fall && (cnt_r == i2css_pkg::ACK_SEEN)) begin
                            cnt_r <= 4'h0;
                            if (tx_busy && stretch_enable) begin
                                state_r <= i2css_pkg::S_HOLD;
                            end else begin
                                sh_r <= tx_src;
                                tx_save_r <= tx_src;
                                st_set_r[i2css_pkg::ST_TXB] <= 1'b1;
                                dly_r <= dly_load;
                                want_r <= !tx_src[7];
                                state_r <= i2css_pkg::S_TX;
                            end
                        end
                    end
                    i2css_pkg::S_HOLD: begin
                        if (!dir_r && !rx_busy) begin
                            rx_data_r <= sh_r;
                            st_set_r[i2css_pkg::ST_RXB] <= 1'b1;
                            dly_r <= dly_load;
                            want_r <= 1'b1;
                            rls_r <= 1'b1;
                            state_r <= i2css_pkg::S_ACK;
                        end else if (dir_r && !tx_busy) begin
                            sh_r <= tx_buf_r;
                            tx_save_r <= tx_buf_r;
                            st_set_r[i2css_pkg::ST_TXB] <= 1'b1;
                            dly_r <= dly_load;
                            want_r <= !tx_buf_r[7];
                            rls_r <= 1'b1;
                            state_r <= i2css_pkg::S_TX;
                        end
                    end
                    default: begin
                        state_r <= i2css_pkg::S_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // i2css_slave
`default_nettype wire

// ---- src/i2css_pkg.sv ----
package i2css_pkg;
    // register offsets on the special-function register port
    localparam logic [7:0] CTRL_OFS = 8'hdb;
    localparam logic [7:0] STAT_OFS = 8'hdc;
    localparam logic [7:0] ADDR_OFS = 8'hdd;
    localparam logic [7:0] DATA_OFS = 8'hde;
    localparam logic [7:0] REG_RESET = 8'h00;
    // control fields
    localparam int CTRL_SRST = 7;
    localparam int CTRL_STRETCH = 1;
    localparam int CTRL_FILT = 0;
    localparam int CTRL_XMT = 0;
    localparam int CTRL_START = 4;
    // status fields; interrupt enables for bits 6 down to 2 sit at the same positions in control
    localparam int ST_FIRST = 7;
    localparam int ST_ADDRM = 6;
    localparam int ST_STOP = 5;
    localparam int ST_RESTART = 4;
    localparam int ST_TXB = 3;
    localparam int ST_RXB = 2;
    localparam int ST_START = 1;
    localparam int ST_NACK = 0;
    localparam int STW_DUAL = 7;
    localparam logic [7:0] IRQ_MASK = 8'h7c;
    localparam logic [7:0] SW_CLR_MASK = 8'h70;
    // address enable bit
    localparam int ADR_EN = 7;
    // timing
    localparam logic [4:0] HOLD_BASE = 5'h03;
    localparam logic [4:0] DLY_FIRE = 5'h01;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] ACK_SEEN = 4'h1;
    localparam int CLK_PERIOD_NS = 10;
    localparam int BUS_DIV = 40;
    localparam logic [5:0] HALF_CYC = 6'(BUS_DIV / 2);
    // master command codes
    localparam logic [1:0] OP_START = 2'h0;
    localparam logic [1:0] OP_STOP = 2'h1;
    localparam logic [1:0] OP_WRITE = 2'h2;
    localparam logic [1:0] OP_READ = 2'h3;
    typedef enum logic [2:0] {
        S_IDLE = 3'h0, S_ADDR = 3'h1, S_RX = 3'h2, S_ACK = 3'h3,
        S_TX = 3'h4, S_MACK = 3'h5, S_HOLD = 3'h6
    } i2css_sst_e;
    typedef enum logic [2:0] {
        M_IDLE = 3'h0, M_STA1 = 3'h1, M_STA2 = 3'h2, M_LOW = 3'h3,
        M_HIGH = 3'h4, M_STO1 = 3'h5, M_STO2 = 3'h6, M_STO3 = 3'h7
    } i2css_mst_e;
endpackage

// ---- src/i2css_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface i2css_if;
    logic m_scl_o;
    logic m_scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic s_scl_o;
    logic s_scl_oe;
    logic s_sda_o;
    logic s_sda_oe;
    logic scl;
    logic sda;
    // open-drain wired and, pulled up when nobody drives low
    assign scl = !((m_scl_oe && !m_scl_o) || (s_scl_oe && !s_scl_o));
    assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));
    modport master (input scl, input sda, output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe);
    modport slave (input scl, input sda, output s_scl_o, output s_scl_oe, output s_sda_o, output s_sda_oe);
endinterface
`default_nettype wire

// ---- src/i2css_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module i2css_master (
    input wire logic clock,
    input wire logic rst_n,
    i2css_if.master bus,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [1:0] cmd_op,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_nack,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_nack
);
    ////////////////////////////////////////////////////////////////////////
    // line sampling
    logic [1:0] sy1_r;
    logic [1:0] sy2_r;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sy1_r <= 2'h3;
            sy2_r <= 2'h3;
        end else begin
            sy1_r <= {bus.scl, bus.sda};
            sy2_r <= sy1_r;
        end
    end
    wire scl_s = sy2_r[1];
    wire sda_s = sy2_r[0];

    ////////////////////////////////////////////////////////////////////////
    // bit sequencer
    i2css_pkg::i2css_mst_e state_r;
    logic [5:0] cnt_r;
    logic [3:0] bit_r;
    logic [8:0] tx_r;
    logic [8:0] rx_r;
    logic held_r;
    logic rsp_valid_r;
    wire need_high = (state_r == i2css_pkg::M_STA1) || (state_r == i2css_pkg::M_HIGH) ||
                     (state_r == i2css_pkg::M_STO2);
    // half period of bus_div/2 core clocks; waits out stretching
    wire advance = !need_high || scl_s;
    wire half_done = advance && (cnt_r == i2css_pkg::HALF_CYC - 6'h01);
    wire scl_drive = ((state_r == i2css_pkg::M_IDLE) && held_r) || (state_r == i2css_pkg::M_LOW) ||
                     (state_r == i2css_pkg::M_STO1);
    wire sda_drive = (state_r == i2css_pkg::M_STA2) || (state_r == i2css_pkg::M_STO1) ||
                     (state_r == i2css_pkg::M_STO2) ||
                     (((state_r == i2css_pkg::M_LOW) || (state_r == i2css_pkg::M_HIGH)) && !tx_r[8]);
    assign cmd_ready = (state_r == i2css_pkg::M_IDLE);
    assign bus.m_scl_o = 1'b0;
    assign bus.m_sda_o = 1'b0;
    assign bus.m_scl_oe = scl_drive;
    assign bus.m_sda_oe = sda_drive;
    assign rsp_valid = rsp_valid_r;
    assign rsp_data = rx_r[8:1];
    assign rsp_nack = rx_r[0];

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= i2css_pkg::M_IDLE;
            cnt_r <= 6'h00;
            bit_r <= 4'h0;
            tx_r <= 9'h1ff;
            rx_r <= 9'h000;
            held_r <= 1'b0;
            rsp_valid_r <= 1'b0;
        end else begin
            rsp_valid_r <= 1'b0;
            if (state_r != i2css_pkg::M_IDLE) begin
                cnt_r <= half_done ? 6'h00 : (advance ? cnt_r + 6'h01 : cnt_r);
            end
            case (state_r)
                i2css_pkg::M_IDLE: begin
                    if (cmd_valid) begin
                        cnt_r <= 6'h00;
                        bit_r <= 4'h0;
                        tx_r <= (cmd_op == i2css_pkg::OP_WRITE) ? {cmd_data, 1'b1} : {8'hff, cmd_nack};
                        case (cmd_op)
                            i2css_pkg::OP_START: state_r <= i2css_pkg::M_STA1;
                            i2css_pkg::OP_STOP: state_r <= i2css_pkg::M_STO1;
                            default: state_r <= i2css_pkg::M_LOW;
                        endcase
                    end
                end
                i2css_pkg::M_STA1: if (half_done) state_r <= i2css_pkg::M_STA2;
                i2css_pkg::M_STA2: begin
                    if (half_done) begin
                        held_r <= 1'b1;
                        state_r <= i2css_pkg::M_IDLE;
                    end
                end
                i2css_pkg::M_LOW: if (half_done) state_r <= i2css_pkg::M_HIGH;
                i2css_pkg::M_HIGH: begin
                    if (half_done) begin
                        rx_r <= {rx_r[7:0], sda_s};
                        tx_r <= {tx_r[7:0], 1'b1};
                        bit_r <= bit_r + 4'h1;
                        if (bit_r == i2css_pkg::BYTE_BITS) begin
                            held_r <= 1'b1;
                            rsp_valid_r <= 1'b1;
                            state_r <= i2css_pkg::M_IDLE;
                        end else begin
                            state_r <= i2css_pkg::M_LOW;
                        end
                    end
                end
                i2css_pkg::M_STO1: if (half_done) state_r <= i2css_pkg::M_STO2;
                i2css_pkg::M_STO2: if (half_done) state_r <= i2css_pkg::M_STO3;
                i2css_pkg::M_STO3: begin
                    if (half_done) begin
                        held_r <= 1'b0;
                        state_r <= i2css_pkg::M_IDLE;
                    end
                end
                default: state_r <= i2css_pkg::M_IDLE;
            endcase
        end
    end
endmodule // i2css_master
`default_nettype wire

// ---- bench/i2css_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module i2css_chk (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda,
    input wire logic m_sda_oe,
    input wire logic s_sda_oe,
    input wire logic s_scl_oe
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////
    idle_after_reset_a: assert property ($rose(rst_n) |-> !s_sda_oe && !s_scl_oe)
        else $error("slave drives bus after reset");
    scl_low_min_a: assert property ($fell(scl) |-> !scl [*8])
        else $error("scl low too short");
    scl_high_min_a: assert property ($rose(scl) |-> scl [*4])
        else $error("scl high too short");
    sda_while_low_a: assert property ($changed(s_sda_oe) |-> !scl)
        else $error("slave sda moved with scl high");
    hold_delay_a: assert property ($changed(s_sda_oe) |-> !$past(scl, 5))
        else $error("slave sda moved too soon");
    stretch_in_low_a: assert property ($rose(s_scl_oe) |-> !$past(scl, 2))
        else $error("stretch outside low phase");
    stretch_release_a: assert property ($fell(s_scl_oe) |-> ##[1:8] scl)
        else $error("scl not freed after stretch");
    start_clock_a: assert property ($rose(m_sda_oe) && scl |-> ##[1:40] !scl)
        else $error("no clock after start");
    ////////////////////////////////////////////////////////////
    cover property ($fell(sda) && scl);
    cover property ($rose(s_scl_oe));
    cover property ($changed(s_sda_oe));
endmodule // i2css_chk
`default_nettype wire

// ---- bench/test_i2c_slave_controller.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
$display("mismatch %s expected %h seen %h", n, e, g); end end
module test_i2c_slave_controller;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic sfr_wr = 1'b0, sfr_rd = 1'b0, cmd_valid = 1'b0, cmd_nack = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, cmd_data = 8'h00;
    logic [1:0] cmd_op = 2'h0;
    logic [7:0] sfr_rdata, rsp_data;
    logic irq, cmd_ready, rsp_valid, rsp_nack;
    int mismatches = 0;
    int total_checks = 0;
    i2css_if bus_if ();
    i2css_slave i2css_slave_i (.clock, .rst_n, .bus(bus_if), .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
        .sfr_rdata, .irq);
    i2css_master i2css_master_i (.clock, .rst_n, .bus(bus_if), .cmd_valid, .cmd_ready, .cmd_op, .cmd_data,
        .cmd_nack, .rsp_valid, .rsp_data, .rsp_nack);
    i2css_chk i2css_chk_i (.clock, .rst_n, .scl(bus_if.scl), .sda(bus_if.sda), .m_sda_oe(bus_if.m_sda_oe),
        .s_sda_oe(bus_if.s_sda_oe), .s_scl_oe(bus_if.s_scl_oe));
    ////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1 {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
        @(posedge clock);
        #1 sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        #1 {sfr_addr, sfr_rd} = {a, 1'b1};
        @(posedge clock);
        #1 sfr_rd = 1'b0;
        `CHK($sformatf("reg %h", a), e, sfr_rdata)
    endtask
    task automatic mc(input logic [1:0] op, input logic [7:0] d, input logic nk);
        int n;
        n = 0;
        @(posedge clock);
        #1 {cmd_op, cmd_data, cmd_nack, cmd_valid} = {op, d, nk, 1'b1};
        while (!cmd_ready) begin
            @(posedge clock);
            #1;
        end
        @(posedge clock);
        #1 cmd_valid = 1'b0;
        while (!(op[1] ? rsp_valid : cmd_ready) && n < 9000) begin
            @(posedge clock);
            #1 n++;
        end
        if (n >= 9000) mismatches++;
    endtask
    task automatic st();
        mc(i2css_pkg::OP_START, 8'h00, 1'b0);
    endtask
    task automatic mw(input logic [7:0] d);
        mc(i2css_pkg::OP_WRITE, d, 1'b0);
    endtask
    task automatic mr(input logic nk);
        mc(i2css_pkg::OP_READ, 8'h00, nk);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        forever #5 clock = ~clock;
    end
    initial begin
        #600000;
        mismatches++;
        test_done;
    end
    initial begin
        repeat (8) @(posedge clock);
        #1 rst_n = 1'b1;
        for (int i = 0; i < 5; i++) rd(8'hdb + 8'(i), 8'h00);
        wr(8'hdd, 8'haa);
        rd(8'hdd, 8'haa);
        wr(8'hdb, 8'h7c);
        st();
        mw(8'h54);
        `CHK("addr ack", 1'b0, rsp_nack)
        mw(8'ha5);
        rd(8'hdc, 8'hc6);
        `CHK("irq", 1'b1, irq)
        rd(8'hdb, 8'h10);
        rd(8'hde, 8'ha5);
        rd(8'hdc, 8'h42);
        mw(8'h11);
        mw(8'h22);
        `CHK("overrun nack", 1'b1, rsp_nack)
        mc(i2css_pkg::OP_STOP, 8'h00, 1'b0);
        rd(8'hdc, 8'h64);
        rd(8'hde, 8'h11);
        wr(8'hdc, 8'h00);
        rd(8'hdc, 8'h00);
        `CHK("irq", 1'b0, irq)
        wr(8'hde, 8'h3c);
        st();
        mw(8'h55);
        mr(1'b0);
        `CHK("tx byte", 8'h3c, rsp_data)
        rd(8'hdb, 8'h11);
        mr(1'b1);
        `CHK("old byte", 8'h3c, rsp_data)
        st();
        mw(8'h55);
        mr(1'b1);
        `CHK("resent byte", 8'h3c, rsp_data)
        mc(i2css_pkg::OP_STOP, 8'h00, 1'b0);
        rd(8'hdc, 8'h79);
        wr(8'hdc, 8'h00);
        wr(8'hdb, 8'h7e);
        wr(8'hde, 8'h5a);
        st();
        mw(8'h55);
        mr(1'b0);
        fork
            mr(1'b1);
            begin
                repeat (60) @(posedge clock);
                wr(8'hde, 8'h69);
            end
        join
        `CHK("stretched byte", 8'h69, rsp_data)
        mc(i2css_pkg::OP_STOP, 8'h00, 1'b0);
        wr(8'hdc, 8'h84);
        wr(8'hdb, 8'h7d);
        st();
        mw(8'h56);
        `CHK("dual ack", 1'b0, rsp_nack)
        mw(8'h77);
        mc(i2css_pkg::OP_STOP, 8'h00, 1'b0);
        rd(8'hde, 8'h77);
        wr(8'hdb, 8'h7e);
        st();
        mw(8'h54);
        mw(8'h13);
        fork
            mw(8'h24);
            begin
                repeat (500) @(posedge clock);
                rd(8'hde, 8'h13);
            end
        join
        `CHK("stretch ack", 1'b0, rsp_nack)
        mc(i2css_pkg::OP_STOP, 8'h00, 1'b0);
        rd(8'hde, 8'h24);
        wr(8'hdb, 8'h80);
        rd(8'hdd, 8'h00);
        test_done;
    end
endmodule // test_i2c_slave_controller
`default_nettype wire
